// ===== dv/spf_ecu_model.sv
// receiving engine controller model: asks for frames and serial messages
module spf_ecu_model (
  // clock
  input  wire logic        pclk,
  // frame side
  input  wire logic        frame_valid,
  input  wire logic [23:0] data_nib,
  input  wire logic [3:0]  status_nib,
  output logic             frame_req,
  // serial side
  input  wire logic        ser_valid,
  input  wire logic        ser_enh,
  input  wire logic [7:0]  ser_id,
  input  wire logic [11:0] ser_data,
  output logic             ser_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  // progress count a receiver watches to catch stuck messages
  int unsigned rx_count = 0;
  initial begin
    frame_req = 1'b0;
    ser_req   = 1'b0;
  end
  // answer is registered on the taking edge, read 1 ns after it, and stands one cycle
  task automatic get_frame(output logic [28:0] f);
    @(posedge pclk);
    frame_req <= 1'b1;
    @(posedge pclk);
    frame_req <= 1'b0;
    #1;
    f = {frame_valid, status_nib, data_nib};
    if (frame_valid === 1'b1) rx_count++;
  endtask
  // the trailing edge keeps enhanced requests at least two cycles apart
  task automatic get_msg(output logic [21:0] m);
    @(posedge pclk);
    ser_req <= 1'b1;
    @(posedge pclk);
    ser_req <= 1'b0;
    #1;
    m = (ser_valid === 1'b1) ? {1'b1, ser_enh, ser_id, ser_data} : 22'h00_0000;
    if (ser_valid === 1'b1) rx_count++;
  endtask
endmodule // spf_ecu_model

// ===== dv/spf_formatter_tb.sv
// self-checking testbench for the payload formatter
module spf_formatter_tb import spf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, frame_req, frame_valid, ser_req, ser_valid, ser_enh, irq;
  logic [23:0] data_nib;
  logic [3:0]  status_nib;
  logic [7:0]  ser_id;
  logic [11:0] ser_data;
  logic [7:0]  leg_byte [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC};
  logic [23:0] split_exp [4] = '{24'hABCD_5A, {14'h2BCD, 10'h25A}, 24'hBCD_E5A, 24'hBCD_E5A};
  int          errors      = 0;
  int          comparisons = 0;

  always #25 pclk = ~pclk;

  spf_formatter u_spf_formatter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_req(frame_req), .frame_valid(frame_valid), .data_nib(data_nib),
    .status_nib(status_nib), .ser_req(ser_req), .ser_valid(ser_valid), .ser_enh(ser_enh),
    .ser_id(ser_id), .ser_data(ser_data), .irq(irq));
  spf_ecu_model u_spf_ecu_model (.pclk(pclk), .frame_valid(frame_valid), .data_nib(data_nib),
    .status_nib(status_nib), .frame_req(frame_req), .ser_valid(ser_valid), .ser_enh(ser_enh),
    .ser_id(ser_id), .ser_data(ser_data), .ser_req(ser_req));
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic tally(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held unchanged until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic chk_reg(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    tally(r, e);
  endtask
  task automatic chk_frm(input logic [28:0] e);
    logic [28:0] f;
    u_spf_ecu_model.get_frame(f);
    tally(f, e);
  endtask
  task automatic chk_ser(input logic [21:0] e);
    logic [21:0] m;
    u_spf_ecu_model.get_msg(m);
    tally(m, e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    tally(irq, e);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(OFF_CTRL, 33'h0_0000_0000);
    chk_reg(OFF_STAT, 33'h0_0000_000F);
    chk_reg(12'h030, 33'h1_0000_0000);
    chk_reg(OFF_XCH, 33'h0_0000_0000);
    $display("test registers done");
    wr(OFF_AUX_TEMP, 32'h0000_1234);
    wr(OFF_AUX_HUM, 32'h0000_5678);
    wr(OFF_AUX_BARO, 32'h0000_9ABC);
    wr(OFF_ERR, 32'h0000_00FF);
    wr(OFF_CTRL, 32'h0000_01C8);
    for (int i = 0; i < 6; i++) begin
      chk_ser({2'b10, i[7:0], 4'h0, leg_byte[i]});
    end
    chk_ser({2'b10, 8'h0F, 12'h03F});
    chk_ser({2'b10, 8'h00, 12'h012});
    wr(OFF_CTRL, 32'h0000_0008);
    chk_ser({2'b10, 8'h0F, 12'h03F});
    chk_ser({2'b10, 8'h0F, 12'h03F});
    wr(OFF_ERR, 32'h0000_0000);
    chk_ser(22'h00_0000);
    wr(OFF_CTRL, 32'h0000_01C0);
    chk_ser(22'h00_0000);
    chk_reg(OFF_IRQ_STAT, 33'h0_0000_0006);
    $display("test legacy serial done");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_XCH + 12'(4 * i), 32'h0000_0A50 + 32'(i));
    end
    wr(OFF_CTRL, 32'h0000_0018);
    for (int i = 0; i < 9; i++) begin
      chk_ser({2'b11, 8'h07 + 8'(i % 8), 12'hA50 + 12'(i % 8)});
    end
    wr(OFF_CTRL, 32'h0000_0009);
    chk_ser({2'b11, 8'h08, 12'hA51});
    $display("test enhanced serial done");
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_FC1, 32'h0000_0123);
    wr(OFF_FC2, 32'h0000_0456);
    chk_frm({1'b1, 4'h0, 24'h123_456});
    wr(OFF_FC1, 32'h0000_0000);
    wr(OFF_FC2, 32'h0000_0FFF);
    chk_frm({1'b1, 4'h0, 24'h001_FF0});
    wr(OFF_ERR, 32'h0000_0300);
    chk_frm({1'b1, 4'h3, 24'hFFF_FFF});
    wr(OFF_ERR, 32'h0000_0200);
    chk_frm({1'b1, 4'h2, 24'h001_FFF});
    $display("test pressure frames done");
    wr(OFF_ERR, 32'h0000_0000);
    wr(OFF_FC1, 32'h0000_ABCD);
    wr(OFF_FC2, 32'h0000_0E5A);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, 32'(s) << 1);
      chk_frm({1'b1, 4'h0, split_exp[s]});
    end
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_FC1, 32'h0000_FFFF);
    wr(OFF_FC2, 32'h0000_00A5);
    chk_frm({1'b1, 4'h0, 24'hFFFF_A5});
    wr(OFF_ERR, 32'h0000_0100);
    chk_frm({1'b1, 4'h1, 24'h0000_A5});
    wr(OFF_CTRL, 32'h0000_0018);
    chk_frm({1'b1, 4'h1, 24'hFFFF_A5});
    wr(OFF_CTRL, 32'h0000_0020);
    chk_frm({1'b1, 4'h1, 24'hFFFF_A5});
    $display("test air flow frames done");
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    chk_reg(OFF_IRQ_STAT, 33'h0_0000_0000);
    wr(OFF_IRQ_EN, 32'h0000_0001);
    chk_irq(1'b0);
    chk_frm({1'b1, 4'h1, 24'hFFFF_A5});
    wr(OFF_IRQ_STAT, 32'h0000_0000);
    chk_reg(OFF_IRQ_STAT, 33'h0_0000_0001);
    chk_irq(1'b1);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    chk_irq(1'b0);
    wr(OFF_IRQ_EN, 32'h0000_0001);
    chk_irq(1'b1);
    wr(OFF_IRQ_CLR, 32'h0000_0001);
    chk_reg(OFF_IRQ_STAT, 33'h0_0000_0000);
    chk_irq(1'b0);
    tally(36'(u_spf_ecu_model.rx_count), 36'd33);
    $display("test interrupt done");
    end_of_test();
  end
  // the tests need a few hundred cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end
endmodule // spf_formatter_tb

// ===== hw/spf_formatter.sv
// payload formatter: frame nibbles, serial message rotation, apb registers
// How it works
// R1 - one serial id set only; legacy short set kept for old air-flow users
// R2 - legacy ids 0-5 carry temperature, humidity, pressure bytes; F carries errors
// R3 - error byte bits 0-5 flag aux out-of-range high/low; bits 6-7 zero
// R4 - error message F skipped while no aux error is active
// R5 - messages of unfitted aux components are never sent
// R6 - enhanced serial forces use of reserved signaling codes
// R7 - legacy air-flow channels without reserved codes use full code range
// R8 - enhanced ids 07-0A carry fast channel 1 transfer characteristic
// R9 - enhanced ids 0B-0E carry fast channel 2 transfer characteristic
// R10 - pressure profile: nibbles 1-3 carry 12-bit fast channel 1
// R11 - pressure profile: nibbles 4-6 carry 12-bit fast channel 2
// R12 - status bit 0 flags channel 1 error, bit 1 channel 2 error
// R13 - pressure profile sends serial messages only in enhanced format
// R14 - pressure measurements never use reserved codes
// R15 - receiver checks rolling count of secure sensors; the formatter sends no rolling count
// R16 - air-flow error without reserved codes zeroes that channel
// R17 - air-flow split is 16+8, 14+10 or 12+12 bits
// R18 - legacy rotation ascends over fitted ids, F only when errors exist
module spf_formatter
  import spf_pkg::*;
#(
  parameter logic [11:0] MEAS_MIN = 12'h001,
  parameter logic [11:0] MEAS_MAX = 12'hFF0,
  parameter logic [11:0] ERR_CODE = 12'hFFF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // frame port toward the nibble engine
  input  wire logic        frame_req,
  output logic             frame_valid,
  output logic      [23:0] data_nib,
  output logic      [3:0]  status_nib,
  // serial message port
  input  wire logic        ser_req,
  output logic             ser_valid,
  output logic             ser_enh,
  output logic      [7:0]  ser_id,
  output logic      [11:0] ser_data,
  // interrupt
  output logic             irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic leg_ok(input logic [3:0] id, input logic [2:0] fit,
                                  input logic err);
    if (id <= LEG_ID_LAST) begin
      return fit[id[2:1]];
    end
    return (id == LEG_ID_ERR) && err;
  endfunction

  // next legacy id after cur, {found, id}; wraps so cur itself is last tried
  function automatic logic [4:0] next_leg(input logic [3:0] cur,
                                          input logic [2:0] fit, input logic err);
    logic [3:0] cand;
    logic [4:0] res;
    res = {1'b0, cur};
    for (int k = 16; k >= 1; k--) begin
      cand = cur + 4'(k);
      if (leg_ok(cand, fit, err)) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction

  function automatic logic [11:0] clamp12(input logic [11:0] v);
    if (v < MEAS_MIN) begin
      return MEAS_MIN;
    end
    if (v > MEAS_MAX) begin
      return MEAS_MAX;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0]         ctrl_q;
  logic [15:0]        fc1_q;
  logic [11:0]        fc2_q;
  logic [15:0]        aux_temp_q;
  logic [15:0]        aux_hum_q;
  logic [15:0]        aux_baro_q;
  logic [9:0]         err_q;
  logic [IRQ_W-1:0]   irq_stat_q;
  logic [IRQ_W-1:0]   irq_en_q;
  logic [IRQ_W-1:0]   irq_set;
  logic [31:0]        rdata_d;
  logic               hit_d;
  logic               wr_acc;
  logic               setup;
  logic [11:0]        xch_rd;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;

  spf_prof_t  prof;
  spf_split_t split;
  logic       ser_on;
  logic       enh_eff;
  logic       rsv_eff;
  logic [2:0] fit;
  logic       aux_err;
  logic       fc1_err;
  logic       fc2_err;

  assign prof    = spf_prof_t'(ctrl_q[CTRL_PROF]);
  assign split   = spf_split_t'(ctrl_q[CTRL_SPLIT +: 2]);
  assign ser_on  = ctrl_q[CTRL_SER];
  assign enh_eff = ctrl_q[CTRL_ENH] || (prof == PROF_PRS);        // see R1 see R13
  assign rsv_eff = ctrl_q[CTRL_RSV] || (ser_on && enh_eff);       // see R6
  assign fit     = ctrl_q[CTRL_FIT +: 3];
  assign aux_err = |err_q[5:0];
  assign fc1_err = err_q[ERR_FC1];
  assign fc2_err = err_q[ERR_FC2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= CTRL_RST;
      fc1_q      <= 16'h0000;
      fc2_q      <= 12'h000;
      aux_temp_q <= 16'h0000;
      aux_hum_q  <= 16'h0000;
      aux_baro_q <= 16'h0000;
      err_q      <= 10'h000;
      irq_en_q   <= '0;
    end else if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL:     ctrl_q     <= pwdata[8:0];
        OFF_FC1:      fc1_q      <= pwdata[15:0];
        OFF_FC2:      fc2_q      <= pwdata[11:0];
        OFF_AUX_TEMP: aux_temp_q <= pwdata[15:0];
        OFF_AUX_HUM:  aux_hum_q  <= pwdata[15:0];
        OFF_AUX_BARO: aux_baro_q <= pwdata[15:0];
        OFF_ERR:      err_q      <= pwdata[9:0];
        OFF_IRQ_EN:   irq_en_q   <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_acc && paddr == OFF_IRQ_CLR) ?
                     pwdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // apb read path, answered in the access cycle from setup-phase flops
  // ----------------------------------------------------------------
  logic [3:0] leg_id_q;
  logic [2:0] enh_idx_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    unique case (paddr)
      OFF_CTRL:     rdata_d = {23'h0, ctrl_q};
      OFF_FC1:      rdata_d = {16'h0, fc1_q};
      OFF_FC2:      rdata_d = {20'h0, fc2_q};
      OFF_AUX_TEMP: rdata_d = {16'h0, aux_temp_q};
      OFF_AUX_HUM:  rdata_d = {16'h0, aux_hum_q};
      OFF_AUX_BARO: rdata_d = {16'h0, aux_baro_q};
      OFF_ERR:      rdata_d = {22'h0, err_q};
      OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
      OFF_IRQ_CLR:  rdata_d = 32'h0000_0000;
      OFF_IRQ_EN:   rdata_d = {29'h0, irq_en_q};
      OFF_STAT:     rdata_d = {22'h0, rsv_eff, enh_eff, 1'b0, enh_idx_q, leg_id_q};
      default: begin
        hit_d = (paddr >= OFF_XCH) && (paddr <= OFF_XCH_END) && (paddr[1:0] == 2'b00);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= !hit_d;
    end
  end

  // ----------------------------------------------------------------
  // transfer characteristic store
  // ----------------------------------------------------------------
  logic xch_wr;
  assign xch_wr = wr_acc && (paddr >= OFF_XCH) && (paddr <= OFF_XCH_END);

  spf_xch_mem #(
    .DEPTH (XCH_DEPTH),
    .WIDTH (12),
    .AW    (3)
  ) u_xch (
    .pclk      (pclk),
    .wr_en     (xch_wr),
    .wr_addr   (paddr[4:2]),
    .wr_data   (pwdata[11:0]),
    .rd_addr   (enh_idx_q),
    .rd_data_q (xch_rd)
  );

  // ----------------------------------------------------------------
  // frame payload
  // ----------------------------------------------------------------
  logic [23:0] nib_d;
  logic [11:0] p1;
  logic [11:0] p2;
  logic [15:0] a1;
  logic [11:0] a2;

  always_comb begin
    // pressure: errors go out as the error code, values stay clear of it
    p1 = fc1_err ? ERR_CODE : clamp12(fc1_q[11:0]);               // see R14
    p2 = fc2_err ? ERR_CODE : clamp12(fc2_q);                     // see R14
    // air flow: full range, error zeroes the channel without reserved codes
    a1 = (fc1_err && !rsv_eff) ? 16'h0000 : fc1_q;                // see R7 see R16
    a2 = (fc2_err && !rsv_eff) ? 12'h000 : fc2_q;                 // see R16
    if (prof == PROF_PRS) begin
      nib_d = {p1, p2};                                           // see R10 see R11
    end else begin
      unique case (split)                                         // see R17
        SPLIT_16_8:  nib_d = {a1, a2[7:0]};
        SPLIT_14_10: nib_d = {a1[13:0], a2[9:0]};
        SPLIT_12_12: nib_d = {a1[11:0], a2};
        default:     nib_d = {a1[11:0], a2};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_nib    <= 24'h00_0000;
      status_nib  <= 4'h0;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= frame_req;
      if (frame_req) begin
        data_nib   <= nib_d;
        status_nib <= {2'b00, fc2_err, fc1_err};                  // see R12
      end
    end
  end

  // ----------------------------------------------------------------
  // serial message rotation
  // ----------------------------------------------------------------
  logic [4:0] leg_nxt;
  logic [7:0] leg_byte;

  assign leg_nxt = next_leg(leg_id_q, fit, aux_err);              // see R4 see R5 see R18

  always_comb begin
    unique case (leg_nxt[3:0])                                    // see R2
      4'h0:    leg_byte = aux_temp_q[15:8];
      4'h1:    leg_byte = aux_temp_q[7:0];
      4'h2:    leg_byte = aux_hum_q[15:8];
      4'h3:    leg_byte = aux_hum_q[7:0];
      4'h4:    leg_byte = aux_baro_q[15:8];
      4'h5:    leg_byte = aux_baro_q[7:0];
      4'hF:    leg_byte = {2'b00, err_q[5:0]};                    // see R3
      default: leg_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leg_id_q  <= LEG_ID_RST;
      enh_idx_q <= 3'd0;
      ser_valid <= 1'b0;
      ser_enh   <= 1'b0;
      ser_id    <= 8'h00;
      ser_data  <= 12'h000;
    end else begin
      ser_valid <= 1'b0;
      if (ser_req && ser_on) begin
        if (enh_eff) begin
          // ids 07-0A for channel 1 then 0B-0E for channel 2
          ser_valid <= 1'b1;
          ser_enh   <= 1'b1;
          ser_id    <= ENH_ID_FC1 + {5'h00, enh_idx_q};           // see R8 see R9
          ser_data  <= xch_rd;
          enh_idx_q <= enh_idx_q + 3'd1;
        end else if (leg_nxt[4]) begin
          ser_valid <= 1'b1;                                      // see R1
          ser_enh   <= 1'b0;
          ser_id    <= {4'h0, leg_nxt[3:0]};
          ser_data  <= {4'h0, leg_byte};
          leg_id_q  <= leg_nxt[3:0];
        end
      end
    end
  end

  assign irq_set = {ser_valid && !ser_enh && ser_id == {4'h0, LEG_ID_ERR},
                    ser_valid, frame_valid};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LEG_IDS: assert property (ser_valid && !ser_enh |->   // see R2
    ser_id <= 8'h05 || ser_id == 8'h0F) else $error("legacy id outside table");
  AST_ERR_BYTE: assert property (ser_valid && !ser_enh && ser_id == 8'h0F |->   // see R3
    ser_data[11:6] == 6'h00 && ser_data[5:0] == $past(err_q[5:0]))
    else $error("error byte layout wrong");
  AST_ERR_SKIP: assert property (ser_valid && !ser_enh && ser_id == 8'h0F |->   // see R4
    $past(aux_err)) else $error("error message sent with no error");
  AST_UNFIT: assert property (ser_valid && !ser_enh && ser_id <= 8'h05 |->   // see R5
    |($past(fit) & (3'b001 << ser_id[2:1]))) else $error("unfitted component message sent");
  AST_PRS_ENH: assert property (ser_valid && $past(prof == PROF_PRS) |->   // see R13
    ser_enh) else $error("pressure profile sent legacy message");
  AST_RSV_ON: assert property (frame_req && prof == PROF_AIR && split == SPLIT_16_8   // see R6
    && ctrl_q[CTRL_SER] && ctrl_q[CTRL_ENH] |=> data_nib[23:8] == $past(fc1_q))
    else $error("reserved codes off with enhanced serial");
  AST_FC1_CHAR: assert property (ser_req && ser_on && enh_eff && !enh_idx_q[2]   // see R8
    |=> ser_id >= 8'h07 && ser_id <= 8'h0A) else $error("channel 1 characteristic id");
  AST_FC2_CHAR: assert property (ser_req && ser_on && enh_eff && enh_idx_q[2]   // see R9
    |=> ser_id >= 8'h0B && ser_id <= 8'h0E) else $error("channel 2 characteristic id");
  AST_PRS_FC1: assert property (frame_req && prof == PROF_PRS && !fc1_err   // see R10
    |=> data_nib[23:12] == clamp12($past(fc1_q[11:0]))) else $error("fc1 nibbles wrong");
  AST_PRS_FC2: assert property (frame_req && prof == PROF_PRS && !fc2_err   // see R11
    |=> data_nib[11:0] == clamp12($past(fc2_q))) else $error("fc2 nibbles wrong");
  AST_STATUS: assert property (frame_req |=>   // see R12
    status_nib[1:0] == $past(err_q[9:8])) else $error("status error flags wrong");
  AST_NO_RSV: assert property (frame_valid && $past(prof == PROF_PRS) |->   // see R14
    data_nib[23:12] >= MEAS_MIN || $past(fc1_err)) else $error("reserved code used");
  AST_FULL: assert property (frame_req && prof == PROF_AIR && split == SPLIT_16_8   // see R7
    && !fc1_err |=> data_nib[23:8] == $past(fc1_q)) else $error("full range lost");
  AST_ZERO: assert property (frame_req && prof == PROF_AIR && fc1_err && !rsv_eff   // see R16
    |=> data_nib[23:12] == 12'h000) else $error("error not zeroed");

  COV_LEG_ERR: cover property (ser_valid && !ser_enh && ser_id == 8'h0F);
  COV_ENH_WRAP: cover property (ser_valid && ser_id == 8'h0E ##[1:20] ser_valid);
  COV_PRS_ERR: cover property (frame_valid && status_nib[1:0] == 2'b11);
  COV_IRQ: cover property (irq);
endmodule // spf_formatter

// ===== hw/spf_xch_mem.sv
// small memory holding transfer characteristic words for the serial rotation
module spf_xch_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 12,
  parameter int AW    = 3
) (
  // clock
  input  wire logic             pclk,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // registered read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read lags the address by one edge; contents are undefined until written
  always_ff @(posedge pclk) begin
    rd_data_q <= mem[rd_addr];
  end
endmodule // spf_xch_mem

// ===== include/spf_pkg.sv
// constants and types shared by the sensor payload formatter
package spf_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_FC1      = 12'h004;
  localparam logic [11:0] OFF_FC2      = 12'h008;
  localparam logic [11:0] OFF_AUX_TEMP = 12'h00C;
  localparam logic [11:0] OFF_AUX_HUM  = 12'h010;
  localparam logic [11:0] OFF_AUX_BARO = 12'h014;
  localparam logic [11:0] OFF_ERR      = 12'h018;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h01C;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h020;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h024;
  localparam logic [11:0] OFF_STAT     = 12'h028;
  localparam logic [11:0] OFF_XCH      = 12'h040;
  localparam logic [11:0] OFF_XCH_END  = 12'h05C;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PROF  = 0;
  localparam int CTRL_SPLIT = 1;
  localparam int CTRL_SER   = 3;
  localparam int CTRL_ENH   = 4;
  localparam int CTRL_RSV   = 5;
  localparam int CTRL_FIT   = 6;
  localparam int ERR_FC1    = 8;
  localparam int ERR_FC2    = 9;
  localparam int IRQ_FRAME  = 0;
  localparam int IRQ_MSG    = 1;
  localparam int IRQ_ERRMSG = 2;
  localparam int IRQ_W      = 3;
  // ----------------------------------------------------------------
  // reset values and message ids
  // ----------------------------------------------------------------
  localparam logic [8:0]  CTRL_RST    = 9'h000;
  localparam logic [3:0]  LEG_ID_RST  = 4'hF;
  localparam logic [3:0]  LEG_ID_LAST = 4'h5;
  localparam logic [3:0]  LEG_ID_ERR  = 4'hF;
  localparam logic [7:0]  ENH_ID_FC1  = 8'h07;
  localparam logic [7:0]  ENH_ID_FC1E = 8'h0A;
  localparam logic [7:0]  ENH_ID_FC2  = 8'h0B;
  localparam logic [7:0]  ENH_ID_FC2E = 8'h0E;
  localparam int          XCH_DEPTH   = 8;

  typedef enum logic [1:0] {
    SPLIT_16_8  = 2'b00,
    SPLIT_14_10 = 2'b01,
    SPLIT_12_12 = 2'b11
  } spf_split_t;
  typedef enum logic {PROF_AIR = 1'b0, PROF_PRS = 1'b1} spf_prof_t;
endpackage
